// *** rtl/fos_defs.vh ***
// constants for the flash operation status reporting block
// assumes a 10 mhz core clock; included by rtl/fos_status.v and fos_top.v
`ifndef FOS_DEFS_VH
`define FOS_DEFS_VH
// =====================================================
// status word bit positions
`define FOS_DATA_POLL_POS 7
`define FOS_PRIMARY_TOGGLE_POS 6
`define FOS_OPERATION_ERROR_POS 5
`define FOS_ERASE_WINDOW_POS 3
`define FOS_SECONDARY_TOGGLE_POS 2
// =====================================================
// timing
`define FOS_CLK_MHZ 10
`define FOS_PROTECT_US 100
`define FOS_ERASE_WINDOW_US 96
`define FOS_PROTECT_CYC (`FOS_PROTECT_US * `FOS_CLK_MHZ)
`define FOS_ERASE_WINDOW_CYC (`FOS_ERASE_WINDOW_US * `FOS_CLK_MHZ)
// =====================================================
// operation controller states
`define FOS_ST_IDLE 3'h0
`define FOS_ST_PROG 3'h1
`define FOS_ST_WAIT 3'h2
`define FOS_ST_ERASE 3'h3
`define FOS_ST_SUSP 3'h4
`define FOS_ST_SPROG 3'h5
`define FOS_ST_PROT 3'h6
`endif

// *** rtl/fos_status.v ***
// status word assembly for the flash operation status block
// assumes the caller supplies the controller state and toggle registers
`include "fos_defs.vh"
module fos_status #(
   parameter DW = 16
) (
   // state
   input wire [2:0] state,
   input wire in_window,
   input wire error_flag,
   input wire t1,
   input wire t2,
   input wire susp_blk_hit,
   input wire prog_addr_hit,
   input wire err_sector_hit,
   input wire [DW-1:0] prog_word,
   // result
   output reg [DW-1:0] status_word
);
   // =====================================================
   // status bits; reserved positions read zero
   always @*
   begin
      status_word = {DW{1'b0}};
      status_word[`FOS_PRIMARY_TOGGLE_POS] = t1;
      status_word[`FOS_SECONDARY_TOGGLE_POS] = t2;
      status_word[`FOS_OPERATION_ERROR_POS] = error_flag;
      status_word[`FOS_ERASE_WINDOW_POS] = ~in_window;
      case (state)
         `FOS_ST_PROG, `FOS_ST_SPROG:
         begin
            // R1 R5
            status_word[`FOS_DATA_POLL_POS] = ~prog_word[7];
            if (state == `FOS_ST_SPROG && prog_addr_hit)
               status_word[`FOS_SECONDARY_TOGGLE_POS] = 1'b1; // R16
         end
         `FOS_ST_SUSP:
         begin
            status_word[`FOS_DATA_POLL_POS] = 1'b1; // R4
            if (susp_blk_hit)
               status_word[`FOS_PRIMARY_TOGGLE_POS] = 1'b1; // R7
         end
         default:
            status_word[`FOS_DATA_POLL_POS] = 1'b0; // R2 R3
      endcase
      if (err_sector_hit)
         status_word[`FOS_SECONDARY_TOGGLE_POS] = t2; // R17
   end
endmodule // fos_status

// *** rtl/fos_top.v ***
// flash operation status reporting: controller state and read mux
// assumes commands are decoded upstream into single-cycle strobes
// Notes on behaviour
// R1 - during program, data poll reads inverse of bit 7 written, then true
// R2 - data poll reads low during erase and high after completion
// R3 - erase of protected block: poll low about 100 us, then array data
// R4 - entering erase suspend switches data poll from low to high
// R5 - program during erase suspend drives data poll like normal program
// R6 - primary toggle inverts per status read; after finish array data returns
// R7 - read from the erase-suspended block forces primary toggle high
// R8 - suspend or resume command inverts primary toggle
// R9 - error bit set on failed program, block erase or chip erase
// R10 - error bit set when program tries to turn zero into one
// R11 - error bit cleared only by read/reset command
// R12 - successful operation: error low while running, data afterwards
// R13 - erase window bit low after last erase command, high after 96 us
// R14 - each status read during erase inverts secondary toggle
// R15 - in suspend, reads or programs into suspended block invert it
// R16 - program in suspend: secondary toggle high at programmed address
// R17 - after failed erase, reads from failed sector keep inverting it
// R18 - software polls at programmed word or inside the erased block
// R19 - reads during an operation return status instead of array data
// R20 - status at bits 7,6,5,3,2; other bits reserved, read zero
// R21 - busy high while program or erase runs; new commands refused
// R22 - reads return array data when no operation is active
`include "fos_defs.vh"
module fos_top #(
   parameter DW = 16,
   parameter AW = 17,
   parameter PROTECT_CYC = `FOS_PROTECT_CYC,
   parameter WINDOW_CYC = `FOS_ERASE_WINDOW_CYC
) (
   // clock and reset
   input wire core_clk,
   input wire nrst,
   // processor read port
   input wire rd_stb,
   input wire [AW-1:0] rd_addr,
   output reg [DW-1:0] rd_data,
   // array data for the current read
   input wire [DW-1:0] array_data,
   // decoded command strobes
   input wire cmd_prog,
   input wire [AW-1:0] cmd_addr,
   input wire [DW-1:0] cmd_data,
   input wire [DW-1:0] cell_data,
   input wire cmd_erase,
   input wire cmd_erase_protected,
   input wire cmd_suspend,
   input wire cmd_resume,
   input wire cmd_read_reset,
   // array operation results
   input wire op_done,
   input wire op_fail,
   // ready/busy
   output wire flash_busy,
   output reg cmd_refused
);
   // =====================================================
   // block address: upper bits select the erase block
   localparam BW = 2;
   function blk_eq;
      input [AW-1:0] a;
      input [AW-1:0] b;
      begin
         blk_eq = (a[AW-1:AW-BW] == b[AW-1:AW-BW]);
      end
   endfunction
   // =====================================================
   // controller registers
   reg [2:0] state;
   reg [AW-1:0] prog_addr;
   reg [DW-1:0] prog_word;
   reg [AW-1:0] erase_addr;
   reg [AW-1:0] fail_addr;
   reg fail_valid;
   reg error_flag;
   reg t1;
   reg t2;
   reg [15:0] timer;
   wire [DW-1:0] status_word;
   wire status_rd;
   wire susp_hit;
   wire err_hit;
   wire running;
   // busy in program, suspended program, erase window, erase and protected-block erase states
   assign running = (state == `FOS_ST_PROG) || (state == `FOS_ST_WAIT) ||
      (state == `FOS_ST_ERASE) || (state == `FOS_ST_SPROG) ||
      (state == `FOS_ST_PROT);
   assign flash_busy = running; // R21
   assign susp_hit = blk_eq(rd_addr, erase_addr);
   assign err_hit = fail_valid && blk_eq(rd_addr, fail_addr);
   // suspended state also substitutes status for the suspended block
   assign status_rd = rd_stb && (running ||
      ((state == `FOS_ST_SUSP) && susp_hit) || err_hit); // R19
   // =====================================================
   // operation sequencer
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= `FOS_ST_IDLE;
         prog_addr <= {AW{1'b0}};
         prog_word <= {DW{1'b0}};
         erase_addr <= {AW{1'b0}};
         timer <= 16'h0000;
         cmd_refused <= 1'b0;
      end
      else
      begin
         cmd_refused <= running && (cmd_prog || cmd_erase ||
            cmd_erase_protected); // R21
         if (timer != 16'h0000)
            timer <= timer - 16'h0001;
         case (state)
            `FOS_ST_IDLE:
            begin
               if (cmd_prog)
               begin
                  state <= `FOS_ST_PROG;
                  prog_addr <= cmd_addr;
                  prog_word <= cmd_data;
               end
               else if (cmd_erase_protected)
               begin
                  state <= `FOS_ST_PROT; // R3
                  erase_addr <= cmd_addr;
                  timer <= PROTECT_CYC[15:0];
               end
               else if (cmd_erase)
               begin
                  state <= `FOS_ST_WAIT; // R13
                  erase_addr <= cmd_addr;
                  timer <= WINDOW_CYC[15:0];
               end
            end
            `FOS_ST_PROT:
               if (timer == 16'h0001)
                  state <= `FOS_ST_IDLE; // R3
            `FOS_ST_WAIT:
               if (timer == 16'h0001)
                  state <= `FOS_ST_ERASE; // R13
            `FOS_ST_PROG:
               if (op_done || op_fail)
                  state <= `FOS_ST_IDLE;
            `FOS_ST_ERASE:
            begin
               if (op_done || op_fail)
                  state <= `FOS_ST_IDLE;
               else if (cmd_suspend)
                  state <= `FOS_ST_SUSP; // R4
            end
            `FOS_ST_SUSP:
            begin
               if (cmd_resume)
                  state <= `FOS_ST_ERASE;
               else if (cmd_prog)
               begin
                  state <= `FOS_ST_SPROG; // R5
                  prog_addr <= cmd_addr;
                  prog_word <= cmd_data;
               end
            end
            `FOS_ST_SPROG:
               if (op_done || op_fail)
                  state <= `FOS_ST_SUSP;
            default:
               state <= `FOS_ST_IDLE;
         endcase
      end
   end
   // =====================================================
   // error flag and failed sector memory
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         error_flag <= 1'b0;
         fail_valid <= 1'b0;
         fail_addr <= {AW{1'b0}};
      end
      else
      begin
         // set beats the read/reset clear in the same cycle
         if ((running && op_fail) || (cmd_prog && !running &&
            ((cmd_data & ~cell_data) != {DW{1'b0}})))
            error_flag <= 1'b1; // R9 R10
         else if (cmd_read_reset)
            error_flag <= 1'b0; // R11
         if (state == `FOS_ST_ERASE && op_fail)
         begin
            fail_valid <= 1'b1; // R17
            fail_addr <= erase_addr;
         end
         else if (cmd_read_reset)
            fail_valid <= 1'b0;
      end
   end
   // =====================================================
   // toggle bits
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         t1 <= 1'b0;
         t2 <= 1'b0;
      end
      else
      begin
         if ((status_rd && running) || cmd_suspend || cmd_resume)
            t1 <= ~t1; // R6 R8
         if (status_rd && ((state == `FOS_ST_ERASE) || err_hit ||
            ((state == `FOS_ST_SUSP) && susp_hit)))
            t2 <= ~t2; // R14 R15 R17
         else if ((state == `FOS_ST_SUSP) && cmd_prog &&
            blk_eq(cmd_addr, erase_addr))
            t2 <= ~t2; // R15
      end
   end
   // =====================================================
   // status assembly
   fos_status #(
      .DW(DW)
   ) u_status (
      .state(state),
      .in_window(state == `FOS_ST_WAIT),
      .error_flag(error_flag),
      .t1(t1),
      .t2(t2),
      .susp_blk_hit(susp_hit),
      .prog_addr_hit(rd_addr == prog_addr),
      .err_sector_hit(err_hit),
      .prog_word(prog_word),
      .status_word(status_word)
   );
   // =====================================================
   // read data register; array data when idle, except reads of the failed erase sector
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         rd_data <= {DW{1'b0}};
      else if (status_rd)
         rd_data <= status_word; // R19 R20 R12
      else if (rd_stb)
         rd_data <= array_data; // R22 R1 R2
   end
endmodule // fos_top

// *** tb/flash_op_status_reporting_tb_top.sv ***
// bench for the flash operation status block
// assumes fos_top, fos_cpu_model and the bound checker
module flash_op_status_reporting_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic cmd_prog, cmd_erase, cmd_erase_protected, cmd_suspend;
   logic cmd_resume, cmd_read_reset, op_done, op_fail;
   logic [16:0] cmd_addr;
   logic [15:0] cmd_data, cell_data, d, w;
   wire rd_stb, flash_busy, cmd_refused;
   wire [16:0] rd_addr;
   wire [15:0] rd_data, array_data, arr_seen;
   int miscompares = 0;
   int total_checks = 0;
   always #50 core_clk = ~core_clk;
   // short counts so the timed states finish quickly
   fos_top #(.PROTECT_CYC(5), .WINDOW_CYC(5)) dut_u (
      .core_clk(core_clk), .nrst(nrst), .rd_stb(rd_stb),
      .rd_addr(rd_addr), .rd_data(rd_data), .array_data(array_data),
      .cmd_prog(cmd_prog), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .cell_data(cell_data), .cmd_erase(cmd_erase),
      .cmd_erase_protected(cmd_erase_protected),
      .cmd_suspend(cmd_suspend), .cmd_resume(cmd_resume),
      .cmd_read_reset(cmd_read_reset), .op_done(op_done),
      .op_fail(op_fail), .flash_busy(flash_busy),
      .cmd_refused(cmd_refused));
   fos_cpu_model cpu_u (.core_clk(core_clk), .rd_stb(rd_stb),
      .rd_addr(rd_addr), .array_data(array_data), .rd_data(rd_data),
      .arr_seen(arr_seen));
   // ==================================================
   // tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge core_clk);
      s = 1'b1;
      @(negedge core_clk);
      s = 1'b0;
   endtask
   task automatic rd_arr(input logic [16:0] a);
      cpu_u.rd(a, d);
      chk(d, arr_seen);
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge core_clk);
      miscompares++;
      tally_and_finish();
   end
   // ==================================================
   // scenarios
   initial
   begin
      {cmd_prog, cmd_erase, cmd_erase_protected, cmd_suspend} = '0;
      {cmd_resume, cmd_read_reset, op_done, op_fail} = '0;
      cmd_addr = '0;
      cmd_data = '0;
      cell_data = 16'hffff;
      void'($urandom(32'h9d1b));
      repeat (12) @(negedge core_clk);
      nrst = 1'b1;
      repeat (3) rd_arr(17'($urandom));
      for (int i = 0; i < 4; i++)
      begin
         cmd_addr = 17'($urandom);
         cmd_data = 16'($urandom);
         cmd_data[7] = i[0];
         pulse(cmd_prog);
         chk(16'(flash_busy), 16'h1);
         cpu_u.rd(cmd_addr, d);
         chk(d & 16'hff13, 16'h0);
         chk(d & 16'h0080, ~cmd_data & 16'h0080);
         cpu_u.rd(cmd_addr, w);
         chk((d ^ w) & 16'h0040, 16'h0040);
         pulse(cmd_erase);
         chk(16'(cmd_refused), 16'h1);
         pulse(op_done);
         rd_arr(cmd_addr);
      end
      cell_data = 16'h0;
      cmd_data = 16'hffff;
      pulse(cmd_prog);
      cpu_u.rd(cmd_addr, d);
      chk(d & 16'h0020, 16'h0020);
      pulse(op_done);
      cell_data = 16'hffff;
      pulse(cmd_read_reset);
      cmd_addr = 17'($urandom);
      pulse(cmd_erase);
      cpu_u.rd(cmd_addr ^ 17'h00ff, d);
      chk(d & 16'h0088, 16'h0);
      repeat (8) @(negedge core_clk);
      cpu_u.rd(cmd_addr, d);
      cpu_u.rd(cmd_addr, w);
      chk(d & 16'h0088, 16'h0008);
      chk((d ^ w) & 16'h0044, 16'h0044);
      pulse(cmd_suspend);
      chk(16'(flash_busy), 16'h0);
      cpu_u.rd(cmd_addr, d);
      chk(d & 16'h00c0, 16'h00c0);
      // program inside the suspended block, then back to suspend
      cmd_addr = cmd_addr ^ 17'h1;
      cmd_data = 16'h0055;
      pulse(cmd_prog);
      cpu_u.rd(cmd_addr, d);
      chk(d & 16'h0084, 16'h0084);
      pulse(op_done);
      cmd_addr = cmd_addr ^ 17'h1;
      pulse(cmd_resume);
      pulse(op_fail);
      cpu_u.rd(cmd_addr, d);
      cpu_u.rd(cmd_addr, w);
      chk(d & 16'h0020, 16'h0020);
      chk((d ^ w) & 16'h0004, 16'h0004);
      pulse(cmd_read_reset);
      rd_arr(cmd_addr);
      pulse(cmd_erase_protected);
      cpu_u.rd(cmd_addr, d);
      chk(d & 16'h0080, 16'h0);
      repeat (10) @(negedge core_clk);
      rd_arr(cmd_addr);
      tally_and_finish();
   end
endmodule // flash_op_status_reporting_tb_top

// *** tb/fos_cpu_model.sv ***
// processor core model: single reads of the flash
// assumes rd_data is valid the cycle after the strobe
module fos_cpu_model (
   // read side
   input wire core_clk,
   output logic rd_stb,
   output logic [16:0] rd_addr,
   output logic [15:0] array_data,
   input wire [15:0] rd_data,
   // array word the block was given
   output logic [15:0] arr_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      rd_stb = 1'b0;
      rd_addr = '0;
      array_data = '0;
      arr_seen = '0;
   end
   // ==================================================
   // one read
   task automatic rd(input logic [16:0] a, output logic [15:0] d);
      @(negedge core_clk);
      rd_stb = 1'b1;
      rd_addr = a;
      array_data = 16'($urandom);
      arr_seen = array_data;
      @(negedge core_clk);
      rd_stb = 1'b0;
      // released lines show the inverse, never a stale value
      rd_addr = ~a;
      array_data = ~arr_seen;
      d = rd_data;
   endtask
endmodule // fos_cpu_model

// *** tb/fos_top_props.sv ***
// checker for the flash operation status block
// assumes a bind onto fos_top with one clock domain
module fos_top_props #(
   parameter DW = 16,
   parameter AW = 17,
   parameter WINDOW_CYC = 5
) (
   // watched ports
   input wire core_clk,
   input wire nrst,
   input wire rd_stb,
   input wire [AW-1:0] rd_addr,
   input wire [DW-1:0] rd_data,
   input wire cmd_prog,
   input wire [AW-1:0] cmd_addr,
   input wire [DW-1:0] cmd_data,
   input wire cmd_erase,
   input wire cmd_erase_protected,
   input wire op_done,
   input wire op_fail,
   input wire flash_busy,
   input wire cmd_refused
);
   // ==================================================
   // helper state
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic in_prog, pb7, rq, q, pok;
   logic [AW-1:0] pa;
   logic [7:0] wc;
   logic [DW-1:0] prev;
   // margin of two cycles: the window edge itself is left open
   wire late = flash_busy && !in_prog && wc > WINDOW_CYC + 2;
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         in_prog <= 1'b0;
         wc <= 8'h0;
         rq <= 1'b0;
         q <= 1'b0;
         pok <= 1'b0;
      end
      else
      begin
         if (cmd_prog && !flash_busy)
         begin
            in_prog <= 1'b1;
            pb7 <= cmd_data[7];
            pa <= cmd_addr;
         end
         else if (op_done || op_fail)
            in_prog <= 1'b0;
         if (cmd_erase && !flash_busy)
            wc <= 8'h1;
         else if (op_done || op_fail)
            wc <= 8'h0;
         else if (wc != 8'h0 && wc != 8'hff)
            wc <= wc + 8'h1;
         rq <= rd_stb;
         q <= rd_stb && late;
         if (rq)
         begin
            pok <= q;
            prev <= rd_data;
         end
      end
   end
   // ==================================================
   // properties
   property p_refuse;
      flash_busy && (cmd_prog || cmd_erase) |=> cmd_refused;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("busy command not refused");
   property p_refuse_cause;
      cmd_refused |-> $past(flash_busy && (cmd_prog || cmd_erase ||
         cmd_erase_protected));
   endproperty
   a_refuse_cause: assert property (p_refuse_cause)
      else $error("refusal without cause");
   property p_rsvd;
      rd_stb && flash_busy |=> (rd_data & 16'hff13) == 16'h0;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved status bits set");
   property p_prog_poll;
      rd_stb && flash_busy && in_prog && rd_addr == pa |=> rd_data[7] != pb7;
   endproperty
   a_prog_poll: assert property (p_prog_poll)
      else $error("poll bit not inverted in program");
   property p_erase_poll;
      rd_stb && flash_busy && !in_prog |=> !rd_data[7];
   endproperty
   a_erase_poll: assert property (p_erase_poll)
      else $error("poll bit high in erase");
   property p_window_lo;
      rd_stb && wc != 8'h0 && wc < WINDOW_CYC - 1 |=> !rd_data[3];
   endproperty
   a_window_lo: assert property (p_window_lo)
      else $error("window bit high in window");
   property p_window_hi;
      rd_stb && late |=> rd_data[3];
   endproperty
   a_window_hi: assert property (p_window_hi)
      else $error("window bit low after window");
   property p_toggle;
      rq && q && pok |-> rd_data[2] != prev[2] && rd_data[6] != prev[6];
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("toggle bits did not flip");
   c_refused: cover property (cmd_refused);
   c_prog_read: cover property (rd_stb && in_prog && flash_busy);
   c_late_pair: cover property (rq && q && pok);
endmodule // fos_top_props

bind fos_top fos_top_props #(
   .DW(DW),
   .AW(AW),
   .WINDOW_CYC(WINDOW_CYC)
) chk_u (
   .core_clk(core_clk), .nrst(nrst), .rd_stb(rd_stb), .rd_addr(rd_addr),
   .rd_data(rd_data), .cmd_prog(cmd_prog), .cmd_addr(cmd_addr),
   .cmd_data(cmd_data), .cmd_erase(cmd_erase),
   .cmd_erase_protected(cmd_erase_protected), .op_done(op_done),
   .op_fail(op_fail), .flash_busy(flash_busy), .cmd_refused(cmd_refused)
);
